/* sce_endpoint.sv */
// Control endpoint top: startup, registers, events, link status and supervision
`timescale 1ns/1ns
module sce_endpoint #(
  parameter int FAR_RESET_CYC = sce_pkg::FAR_RESET_CYC,
  parameter int STUCK_CYC = sce_pkg::STUCK_TIMEOUT_CYC
) (
  // Clock, reset and clock enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Enable pin and power state
  input wire logic enable_pin,
  output logic low_power,
  // Control port
  input wire logic control_select_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso_out,
  output logic spi_miso_oe,
  // Rate pins, sensed as low, float or high
  input wire logic [1:0] rate_pin_a,
  input wire logic [1:0] rate_pin_b,
  output logic [6:0] link_baud_factor,
  // Link engine
  input wire logic link_established,
  input wire logic [3:0] far_rate_index,
  input wire logic far_int_n,
  input wire logic data_bus_idle,
  input wire logic link_fault_evt,
  input wire logic tx_overflow_evt,
  input wire logic rx_underflow_evt,
  // Open-drain status pins
  output logic link_n_out,
  output logic link_n_oe,
  output logic int_n_out,
  output logic int_n_oe,
  // Far bus supervision
  input wire logic [2:0] far_select_n,
  input wire logic far_sck,
  output logic far_bus_reset,
  output logic far_reset_req,
  output logic far_drive_en,
  // Configuration to the data path
  output logic [5:0] spi_mode_cfg,
  output logic [5:0] word_length
);
  localparam int RW = $clog2(sce_pkg::READY_CYC + 1);
  localparam int SW = $clog2(sce_pkg::INT_SAMPLE_CYC + 1);
  localparam int FW = $clog2(FAR_RESET_CYC + 1);
  localparam int TW = $clog2(STUCK_CYC + 1);

  // Elaboration check on the long counts
  if (FAR_RESET_CYC < 1 || STUCK_CYC < 2) begin : g_bad_param
    $error("sce_endpoint: counts too small");
  end

  sce_frame_if fr ();
  sce_pkg::sce_state_t state_r, state_nxt;
  logic [RW-1:0] init_cnt_r;
  logic [SW-1:0] samp_cnt_r;
  logic [FW-1:0] far_cnt_r;
  logic [TW-1:0] stuck_cnt_r;
  logic [1:0] on_m_r, on_s_r;
  logic [3:0] rate_m_r, rate_s_r, idx_r;
  logic [3:0] far_m_r, far_s_r;
  logic far_sck_q_r, link_q_r, mirror_r;
  logic [5:0] cfg_r, wlen_r;
  logic [2:0] ev_r, ien_r;
  logic [4:0] fault_r;
  logic [7:0] scratch_r;
  logic low_power_r, link_oe_r, int_oe_r, far_bus_reset_r, far_req_r, far_en_r;
  logic [6:0] baud_r;

  // Control serial engine
  sce_ctrl_spi i_sce_ctrl_spi (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .active(state_r == sce_pkg::SCE_READY),
    .select_n_pin(control_select_n),
    .sck_pin(spi_sck),
    .mosi_pin(spi_mosi),
    .miso(spi_miso_out),
    .miso_oe(spi_miso_oe),
    .fr(fr)
  );

  // Startup sequence decode
  wire on_s = on_s_r[1];
  wire ready = state_r == sce_pkg::SCE_READY;
  wire init_done = init_cnt_r == RW'(sce_pkg::READY_CYC - 1);
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sce_pkg::SCE_OFF: state_nxt = on_s ? sce_pkg::SCE_INIT : sce_pkg::SCE_OFF;
      sce_pkg::SCE_INIT: state_nxt = !on_s ? sce_pkg::SCE_OFF :
                                     init_done ? sce_pkg::SCE_READY : sce_pkg::SCE_INIT;
      sce_pkg::SCE_READY: state_nxt = on_s ? sce_pkg::SCE_READY : sce_pkg::SCE_OFF;
      default: state_nxt = sce_pkg::SCE_OFF;
    endcase
  end

  // Link and interrupt decode
  wire link_ok = ready && link_established && far_rate_index == idx_r;
  wire good_set = link_ok && !link_q_r;
  wire lost_set = !link_ok && link_q_r && ready;
  wire irq = |(ev_r & ien_r);
  wire samp_tick = samp_cnt_r == SW'(sce_pkg::INT_SAMPLE_CYC - 1);

  // Far bus stuck detection: a select held with no clock edge
  wire far_sel_act = ~&far_s_r[2:0];
  wire far_edge = far_s_r[3] ^ far_sck_q_r;
  wire stuck_fire = far_sel_act && !far_edge && stuck_cnt_r == TW'(STUCK_CYC - 1);
  wire [4:0] fault_set = {rx_underflow_evt, tx_overflow_evt, stuck_fire, link_fault_evt,
                          fr.wr_fault};

  // Far reset condition: enable low or link down
  wire far_cond = !on_s || (ready && !link_ok);
  wire far_hit = far_cnt_r == FW'(FAR_RESET_CYC);

  // Register write strobes
  wire we_cfg = fr.wr_commit && fr.addr == sce_pkg::A_CONFIG;
  wire we_ev = fr.wr_commit && fr.addr == sce_pkg::A_EVENT;
  wire we_ien = fr.wr_commit && fr.addr == sce_pkg::A_INT_EN;
  wire we_scr = fr.wr_commit && fr.addr == sce_pkg::A_SCRATCH;
  wire we_wlen = fr.wr_commit && fr.addr == sce_pkg::A_WORD_LEN &&
                 fr.wdata >= sce_pkg::WORD_LEN_MIN && fr.wdata <= sce_pkg::WORD_LEN_MAX;
  wire [2:0] ev_clr = we_ev ? ~fr.wdata[2:0] : 3'h0;
  wire [2:0] ev_set = {|fault_set, lost_set, good_set};
  wire [7:0] status = {idx_r, 1'b0, mirror_r, ~int_oe_r, ~link_oe_r};

  // Read data selection, unmapped offsets read zero
  assign fr.rdata = (fr.addr == sce_pkg::A_CONFIG) ? {2'h0, cfg_r} :
                    (fr.addr == sce_pkg::A_STATUS) ? status :
                    (fr.addr == sce_pkg::A_EVENT) ? {5'h00, ev_r} :
                    (fr.addr == sce_pkg::A_INT_EN) ? {5'h00, ien_r} :
                    (fr.addr == sce_pkg::A_FAULT) ? {3'h0, fault_r} :
                    (fr.addr == sce_pkg::A_WORD_LEN) ? {2'h0, wlen_r} :
                    (fr.addr == sce_pkg::A_SCRATCH) ? scratch_r : 8'h00;

  // Outputs
  assign low_power = low_power_r;
  assign link_baud_factor = baud_r;
  assign link_n_out = 1'b0;
  assign link_n_oe = link_oe_r;
  assign int_n_out = 1'b0;
  assign int_n_oe = int_oe_r;
  assign far_bus_reset = far_bus_reset_r;
  assign far_reset_req = far_req_r;
  assign far_drive_en = far_en_r;
  assign spi_mode_cfg = cfg_r;
  assign word_length = wlen_r;

  // Pin synchronisers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      on_m_r <= 2'h0;
      on_s_r <= 2'h0;
      rate_m_r <= 4'h0;
      rate_s_r <= 4'h0;
      far_m_r <= 4'hF;
      far_s_r <= 4'hF;
      far_sck_q_r <= 1'b1;
    end else if (clk_en) begin
      on_m_r <= {on_m_r[0], enable_pin};
      on_s_r <= {on_s_r[0], on_m_r[1]};
      rate_m_r <= {rate_pin_a, rate_pin_b};
      rate_s_r <= rate_m_r;
      far_m_r <= {far_sck, far_select_n};
      far_s_r <= far_m_r;
      far_sck_q_r <= far_s_r[3];
    end
  end

  // Startup state and counters
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= sce_pkg::SCE_OFF;
      init_cnt_r <= '0;
      low_power_r <= 1'b1;
      idx_r <= 4'h0;
      baud_r <= 7'h01;
    end else if (clk_en) begin
      state_r <= state_nxt;
      init_cnt_r <= (state_r == sce_pkg::SCE_INIT) ? init_cnt_r + RW'(1) : '0;
      low_power_r <= !on_s;
      idx_r <= sce_pkg::rate_index(rate_s_r[3:2], rate_s_r[1:0]);
      baud_r <= sce_pkg::baud_factor(idx_r);
    end
  end

  // Configuration registers, defaults while enable is low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= sce_pkg::RST_CONFIG;
      ien_r <= sce_pkg::RST_INT_EN;
      wlen_r <= sce_pkg::RST_WORD_LEN;
      scratch_r <= sce_pkg::RST_SCRATCH;
    end else if (clk_en) begin
      if (!on_s) begin
        cfg_r <= sce_pkg::RST_CONFIG;
        ien_r <= sce_pkg::RST_INT_EN;
        wlen_r <= sce_pkg::RST_WORD_LEN;
        scratch_r <= sce_pkg::RST_SCRATCH;
      end else begin
        if (we_cfg) cfg_r <= fr.wdata[5:0];
        if (we_ien) ien_r <= fr.wdata[2:0];
        if (we_wlen) wlen_r <= fr.wdata[5:0];
        if (we_scr) scratch_r <= fr.wdata;
      end
    end
  end

  // Sticky events and faults; a new set wins over a clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ev_r <= 3'h0;
      fault_r <= 5'h00;
      link_q_r <= 1'b0;
    end else if (clk_en) begin
      link_q_r <= link_ok;
      if (!on_s) begin
        ev_r <= 3'h0;
        fault_r <= 5'h00;
      end else begin
        ev_r <= (ev_r & ~ev_clr) | ev_set;
        fault_r <= (fault_r & ~{5{ev_clr[sce_pkg::EV_FAULT]}}) | fault_set;
      end
    end
  end

  // Interrupt mirror and open-drain enables
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      samp_cnt_r <= '0;
      mirror_r <= 1'b1;
      link_oe_r <= 1'b0;
      int_oe_r <= 1'b0;
    end else if (clk_en) begin
      samp_cnt_r <= samp_tick ? '0 : samp_cnt_r + SW'(1);
      if (!link_ok) mirror_r <= 1'b1;
      else if (samp_tick && data_bus_idle) mirror_r <= far_int_n;
      link_oe_r <= link_ok;
      int_oe_r <= ready && !(mirror_r && !irq);
    end
  end

  // Far bus timeout and far reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stuck_cnt_r <= '0;
      far_bus_reset_r <= 1'b0;
      far_cnt_r <= '0;
      far_req_r <= 1'b0;
      far_en_r <= 1'b0;
    end else if (clk_en) begin
      stuck_cnt_r <= (!far_sel_act || far_edge || stuck_fire) ? '0 : stuck_cnt_r + TW'(1);
      far_bus_reset_r <= stuck_fire;
      far_cnt_r <= !far_cond ? '0 : far_hit ? far_cnt_r : far_cnt_r + FW'(1);
      far_req_r <= far_cond && far_hit;
      if (far_req_r) far_en_r <= 1'b0;
      else if (link_ok) far_en_r <= 1'b1;
    end
  end

  // Sequences for the startup checks
  sequence s_off2;
    !on_s ##1 !on_s;
  endsequence

  a_init_float: assert property (@(posedge mclk) disable iff (!reset_n)
    !ready && !$past(ready) |-> !link_oe_r && !int_oe_r)
    else $error("pin driven before ready");
  a_off_defaults: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en throughout s_off2 |=> cfg_r == sce_pkg::RST_CONFIG && ien_r == 3'h0 && low_power_r)
    else $error("configuration kept while disabled");
  a_link_pull: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && link_ok |=> link_oe_r)
    else $error("link up but status not pulled");
  a_rate_match: assert property (@(posedge mclk) disable iff (!reset_n)
    link_oe_r |-> $past(far_rate_index == idx_r))
    else $error("link declared with differing rates");
  a_irq_drive: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && ready && irq |=> int_oe_r)
    else $error("enabled event did not pull interrupt");
  a_irq_and: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && ready && mirror_r && !irq |=> !int_oe_r)
    else $error("interrupt held with both sources high");
  a_fault_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && on_s && we_ev && !fr.wdata[2] && fault_set == 5'h00 |=> fault_r == 5'h00)
    else $error("fault flags survived event clear");
  a_stuck_reset: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && stuck_fire |=> far_bus_reset_r ##1 !far_bus_reset_r || !clk_en)
    else $error("stuck bus not reset");
  a_far_reset: assert property (@(posedge mclk) disable iff (!reset_n)
    far_req_r |=> !far_en_r || !clk_en)
    else $error("far outputs left on after far reset");
  // Supervision and control-port checks
  a_far_req: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && far_cond && far_hit |=> far_req_r)
    else $error("far reset not requested after hold time");
  a_stuck_fault: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && on_s && stuck_fire |=> fault_r[sce_pkg::FL_REMSPI])
    else $error("stuck bus not flagged as fault");
  a_miso_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !ready |=> !spi_miso_oe)
    else $error("control data driven before ready");
endmodule

/* sce_pkg.sv */
// Constants, rate table and check-byte function for the control endpoint
// What this block does
// - Outputs float until initialization completes
// - Control port answers only after ready time
// - Established link pulls link status low
// - Enable low resets configuration, disables drivers
// - Link status is open-drain, off at startup
// - No link when rate indexes differ
// - Far interrupt sampled periodically while bus idle
// - Interrupt output ANDs far and local levels
// - Enabled set event drives interrupt low
// - Reset far bus on stuck select
// - Far reset after enable low or link loss
// - Far outputs off until link returns
// - Rate pins decode to index and factor
// - Only modes (0,0) and (1,1) accepted
// - MSB first; address then read bit
// - Exactly one data byte per transfer
// - Optional write check byte, CRC-8 poly 07
// - Bad check byte discards write, flags fault
// - Read returns CRC over address and data
// - Clearing fault event clears all faults
// - Incomplete write after address flags fault
package sce_pkg;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int READY_US = 10;
  localparam int READY_CYC = READY_US * CLK_MHZ;
  localparam int INT_SAMPLE_US = 10;
  localparam int INT_SAMPLE_CYC = INT_SAMPLE_US * CLK_MHZ;
  localparam int FAR_RESET_US = 1000;
  localparam int FAR_RESET_CYC = FAR_RESET_US * CLK_MHZ;
  localparam int STUCK_TIMEOUT_US = 100;
  localparam int STUCK_TIMEOUT_CYC = STUCK_TIMEOUT_US * CLK_MHZ;
  // Register offsets
  localparam logic [6:0] A_CONFIG = 7'h00;
  localparam logic [6:0] A_STATUS = 7'h01;
  localparam logic [6:0] A_EVENT = 7'h02;
  localparam logic [6:0] A_INT_EN = 7'h03;
  localparam logic [6:0] A_FAULT = 7'h04;
  localparam logic [6:0] A_WORD_LEN = 7'h05;
  localparam logic [6:0] A_SCRATCH = 7'h06;
  // Field positions
  localparam int EV_GOOD = 0;
  localparam int EV_LOST = 1;
  localparam int EV_FAULT = 2;
  localparam int FL_WRITE = 0;
  localparam int FL_LINK = 1;
  localparam int FL_REMSPI = 2;
  localparam int FL_TXOVF = 3;
  localparam int FL_RXUNF = 4;
  // Reset values and limits
  localparam logic [5:0] RST_CONFIG = 6'h00;
  localparam logic [2:0] RST_INT_EN = 3'h0;
  localparam logic [5:0] RST_WORD_LEN = 6'h08;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] WORD_LEN_MIN = 8'h08;
  localparam logic [7:0] WORD_LEN_MAX = 8'h20;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // Frame bit counts
  localparam logic [5:0] BITS_ADDR = 6'h08;
  localparam logic [5:0] BITS_DATA = 6'h10;
  localparam logic [5:0] BITS_CRC = 6'h18;
  // Three-state pin sense codes
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_FLOAT = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;

  typedef enum logic [1:0] {
    SCE_OFF = 2'b00,
    SCE_INIT = 2'b01,
    SCE_READY = 2'b10
  } sce_state_t;

  // One byte through the check register, MSB first, no reflection
  function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[7] ^ data[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Rate pin pair to speed index
  function automatic logic [3:0] rate_index(input logic [1:0] a, input logic [1:0] b);
    case ({a, b})
      {PIN_LOW, PIN_LOW}: return 4'h8;
      {PIN_FLOAT, PIN_LOW}: return 4'h7;
      {PIN_HIGH, PIN_LOW}: return 4'h6;
      {PIN_LOW, PIN_FLOAT}: return 4'h5;
      {PIN_FLOAT, PIN_FLOAT}: return 4'h4;
      {PIN_LOW, PIN_HIGH}: return 4'h3;
      {PIN_HIGH, PIN_FLOAT}: return 4'h2;
      {PIN_FLOAT, PIN_HIGH}: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction

  // Speed index to baud factor
  function automatic logic [6:0] baud_factor(input logic [3:0] idx);
    case (idx)
      4'h8: return 7'h01;
      4'h7: return 7'h02;
      4'h6: return 7'h04;
      4'h5: return 7'h08;
      4'h4: return 7'h10;
      4'h3: return 7'h18;
      4'h2: return 7'h20;
      4'h1: return 7'h40;
      default: return 7'h50;
    endcase
  endfunction
endpackage

/* sce_frame_if.sv */
// Frame results passed from the control serial engine to the register file
`timescale 1ns/1ns
interface sce_frame_if;
  logic wr_commit;
  logic wr_fault;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport serial (output wr_commit, output wr_fault, output addr, output wdata, input rdata);
  modport regs (input wr_commit, input wr_fault, input addr, input wdata, output rdata);
endinterface

/* sce_ctrl_spi.sv */
// Serial engine of the control port: shifting, check bytes, commit decision
`timescale 1ns/1ns
module sce_ctrl_spi (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic active,
  // Control port pins
  input wire logic select_n_pin,
  input wire logic sck_pin,
  input wire logic mosi_pin,
  output logic miso,
  output logic miso_oe,
  // Frame results
  sce_frame_if.serial fr
);
  logic [2:0] s1_r, s2_r;
  logic sck_q_r, cs_q_r, load_rd_r, load_crc_r;
  logic [5:0] cnt_r;
  logic [7:0] rx_r, tx_r, abyte_r, wdata_r, crcb_r, crc_a_r, rd_r;
  logic commit_r, fault_r, miso_r, oe_r;

  // Edge and frame decode
  wire cs_act = ~s2_r[2] & active;
  wire sck_rise = s2_r[1] & ~sck_q_r;
  wire sck_fall = ~s2_r[1] & sck_q_r;
  wire frame_start = cs_act & ~cs_q_r;
  wire frame_end = ~cs_act & cs_q_r;
  wire [7:0] rx_byte = {rx_r[6:0], s2_r[0]};
  wire [7:0] wr_crc = sce_pkg::crc_byte(crc_a_r, wdata_r);
  wire is_wr = ~abyte_r[0];
  wire past_addr = cnt_r >= sce_pkg::BITS_ADDR;
  wire good_len = (cnt_r == sce_pkg::BITS_DATA) ||
                  (cnt_r == sce_pkg::BITS_CRC && crcb_r == wr_crc);
  assign fr.addr = abyte_r[7:1];
  assign fr.wdata = wdata_r;
  assign fr.wr_commit = commit_r;
  assign fr.wr_fault = fault_r;
  assign miso = miso_r;
  assign miso_oe = oe_r;

  // Pin synchronisers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= 3'h7;
      s2_r <= 3'h7;
      sck_q_r <= 1'b1; // Matches the synchroniser reset, so no false edge
      cs_q_r <= 1'b0;
    end else if (clk_en) begin
      s1_r <= {select_n_pin, sck_pin, mosi_pin};
      s2_r <= s1_r;
      sck_q_r <= s2_r[1];
      cs_q_r <= cs_act;
    end
  end

  // Receive side: capture on rising clock, modes (0,0) and (1,1) only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 6'h00;
      rx_r <= 8'h00;
      abyte_r <= 8'h01;
      wdata_r <= 8'h00;
      crcb_r <= 8'h00;
      crc_a_r <= 8'h00;
    end else if (clk_en) begin
      if (frame_start) begin
        cnt_r <= 6'h00;
      end else if (cs_act && sck_rise) begin
        rx_r <= rx_byte;
        cnt_r <= (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;
        if (cnt_r == sce_pkg::BITS_ADDR - 6'h01) begin
          abyte_r <= rx_byte;
          crc_a_r <= sce_pkg::crc_byte(8'h00, rx_byte);
        end
        if (cnt_r == sce_pkg::BITS_DATA - 6'h01) begin
          wdata_r <= rx_byte;
        end
        if (cnt_r == sce_pkg::BITS_CRC - 6'h01) begin
          crcb_r <= rx_byte;
        end
      end
    end
  end

  // Transmit side: load read data, then its check byte, launch on falling clock
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      load_rd_r <= 1'b0;
      load_crc_r <= 1'b0;
      tx_r <= 8'h00;
      rd_r <= 8'h00;
      miso_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (clk_en) begin
      load_rd_r <= cs_act && sck_rise && cnt_r == sce_pkg::BITS_ADDR - 6'h01;
      load_crc_r <= cs_act && sck_rise && cnt_r == sce_pkg::BITS_DATA - 6'h01;
      oe_r <= cs_act;
      if (frame_start) begin
        tx_r <= 8'h00;
      end else if (load_rd_r) begin
        tx_r <= fr.rdata;
        rd_r <= fr.rdata;
      end else if (load_crc_r) begin
        tx_r <= sce_pkg::crc_byte(crc_a_r, rd_r);
      end else if (cs_act && sck_fall) begin
        miso_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Commit or fault at the end of a write frame
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      commit_r <= 1'b0;
      fault_r <= 1'b0;
    end else if (clk_en) begin
      commit_r <= frame_end && past_addr && is_wr && good_len;
      fault_r <= frame_end && past_addr && is_wr && !good_len;
    end
  end

  a_commit_len: assert property (@(posedge mclk) disable iff (!reset_n)
    commit_r |-> is_wr && (cnt_r == sce_pkg::BITS_DATA || cnt_r == sce_pkg::BITS_CRC))
    else $error("commit without a complete write frame");
  a_crc_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    commit_r && cnt_r == sce_pkg::BITS_CRC |-> crcb_r == wr_crc)
    else $error("write committed with wrong check byte");
  a_read_crc: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && load_crc_r |=> tx_r == sce_pkg::crc_byte(crc_a_r, rd_r))
    else $error("read check byte not loaded");
  a_short_fault: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && frame_end && is_wr && cnt_r > sce_pkg::BITS_ADDR && cnt_r < sce_pkg::BITS_DATA
    |=> fault_r && !commit_r)
    else $error("short write frame not flagged");
endmodule

/* sce_ctrl_master.sv */
// Local control-port master model that drives the endpoint's control select
`timescale 1ns/1ns
module sce_ctrl_master (
  // Clock
  input wire logic mclk,
  // Control port
  output logic control_select_n,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso_out
);
  logic cpol = 1'h0;

  // Idle levels before the first frame
  initial begin
    control_select_n = 1'h1;
    spi_sck = 1'h0;
    spi_mosi = 1'h0;
  end

  // Shift n bits MSB first; launch on falling clock, capture on rising clock
  task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = 24'h0;
    @(posedge mclk) spi_sck <= cpol;
    repeat (6) @(posedge mclk);
    control_select_n <= 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (6) @(posedge mclk);
      spi_sck <= 1'h0;
      spi_mosi <= tx[i];
      repeat (6) @(posedge mclk);
      rx = {rx[22:0], spi_miso_out};
      spi_sck <= 1'h1;
    end
    repeat (6) @(posedge mclk);
    spi_sck <= cpol;
    repeat (6) @(posedge mclk);
    control_select_n <= 1'h1;
    spi_mosi <= ~spi_mosi;
    repeat (10) @(posedge mclk);
  endtask
endmodule

/* test_spi_extender_control_endpoint.sv */
// Self-checking bench for the control endpoint
`timescale 1ns/1ns
module test_spi_extender_control_endpoint;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic enable_pin = 1'h0;
  logic link_established = 1'h0;
  logic far_int_n = 1'h1;
  logic data_bus_idle = 1'h1;
  logic tx_overflow_evt = 1'h0;
  logic far_sck = 1'h0;
  logic [1:0] rate_pin_a = 2'h0;
  logic [1:0] rate_pin_b = 2'h0;
  logic [3:0] far_rate_index = 4'h8;
  logic [2:0] far_select_n = 3'h7;
  logic csn, sck, mosi, miso, miso_oe, low_power, link_n_oe, int_n_oe;
  logic far_bus_reset, far_reset_req, far_drive_en;
  logic [6:0] baud;
  logic [5:0] word_len;
  logic [5:0] mode_cfg;
  logic [1:0] od;
  logic [23:0] rx;
  int failures = 0;
  int num_checks = 0;
  int pa[9] = '{0, 1, 2, 0, 1, 0, 2, 1, 2};
  int pb[9] = '{0, 0, 0, 1, 1, 2, 1, 2, 2};
  int fac[9] = '{1, 2, 4, 8, 16, 24, 32, 64, 80};
  int k;

  sce_ctrl_master i_sce_ctrl_master (.mclk(mclk), .control_select_n(csn), .spi_sck(sck),
    .spi_mosi(mosi), .spi_miso_out(miso));

  sce_endpoint #(.FAR_RESET_CYC(50), .STUCK_CYC(40)) i_sce_endpoint (.mclk(mclk),
    .reset_n(reset_n), .clk_en(1'h1), .enable_pin(enable_pin), .low_power(low_power),
    .control_select_n(csn), .spi_sck(sck), .spi_mosi(mosi), .spi_miso_out(miso),
    .spi_miso_oe(miso_oe), .rate_pin_a(rate_pin_a), .rate_pin_b(rate_pin_b),
    .link_baud_factor(baud), .link_established(link_established),
    .far_rate_index(far_rate_index), .far_int_n(far_int_n), .data_bus_idle(data_bus_idle),
    .link_fault_evt(1'h0), .tx_overflow_evt(tx_overflow_evt), .rx_underflow_evt(1'h0),
    .link_n_out(od[1]), .link_n_oe(link_n_oe), .int_n_out(od[0]), .int_n_oe(int_n_oe),
    .far_select_n(far_select_n), .far_sck(far_sck), .far_bus_reset(far_bus_reset),
    .far_reset_req(far_reset_req), .far_drive_en(far_drive_en), .spi_mode_cfg(mode_cfg),
    .word_length(word_len));

  // Clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  // Compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Check byte over two bytes, MSB first, start value zero
  function automatic logic [7:0] crc8(input logic [15:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ m[i]) ? ({c[6:0], 1'h0} ^ 8'h07) : {c[6:0], 1'h0};
    end
    return c;
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Plain write, or write with a correct or corrupted check byte
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_sce_ctrl_master.xfer({8'h00, a, 1'h0, d}, 16, rx);
  endtask

  task automatic wrc(input logic [6:0] a, input logic [7:0] d, input logic good);
    logic [7:0] c;
    c = good ? crc8({a, 1'h0, d}) : ~crc8({a, 1'h0, d});
    i_sce_ctrl_master.xfer({a, 1'h0, d, c}, 24, rx);
  endtask

  // Read a register and its trailing check byte
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    i_sce_ctrl_master.xfer({a, 1'h1, 16'h0}, 24, rx);
    chk("read data", rx[15:8], e);
    chk("read check byte", rx[7:0], crc8({a, 1'h1, e}));
  endtask

  task automatic complete_run;
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    failures++;
    complete_run();
  end

  // Test sequence
  initial begin
    wt(3);
    reset_n <= 1'h1;
    enable_pin <= 1'h1;
    wt(2);
    chk("startup drivers", 8'({link_n_oe, int_n_oe, miso_oe}), 8'h00);
    chk("open-drain data", 8'(od), 8'h00);
    wr(sce_pkg::A_SCRATCH, 8'hA5);
    wt(1000);
    rd(sce_pkg::A_SCRATCH, 8'h00);
    wr(sce_pkg::A_SCRATCH, 8'h3C);
    rd(sce_pkg::A_SCRATCH, 8'h3C);
    wr(sce_pkg::A_CONFIG, 8'h2D);
    chk("mode config", 8'(mode_cfg), 8'h2D);
    i_sce_ctrl_master.cpol = 1'h1;
    wrc(sce_pkg::A_WORD_LEN, 8'h20, 1'h1);
    chk("word length", 8'(word_len), 8'h20);
    i_sce_ctrl_master.cpol = 1'h0;
    wr(sce_pkg::A_INT_EN, 8'h04);
    i_sce_ctrl_master.xfer({12'h0, sce_pkg::A_SCRATCH, 1'h0, 4'hF}, 12, rx);
    rd(sce_pkg::A_FAULT, 8'h01);
    chk("interrupt", 8'(int_n_oe), 8'h01);
    wr(sce_pkg::A_EVENT, 8'h00);
    rd(sce_pkg::A_FAULT, 8'h00);
    chk("interrupt", 8'(int_n_oe), 8'h00);
    wrc(sce_pkg::A_SCRATCH, 8'h11, 1'h0);
    i_sce_ctrl_master.xfer({16'h0, sce_pkg::A_SCRATCH, 1'h0}, 8, rx);
    rd(sce_pkg::A_SCRATCH, 8'h3C);
    rd(sce_pkg::A_FAULT, 8'h01);
    tx_overflow_evt <= 1'h1;
    wt(1);
    tx_overflow_evt <= 1'h0;
    rd(sce_pkg::A_FAULT, 8'h09);
    wr(sce_pkg::A_INT_EN, 8'h00);
    chk("interrupt", 8'(int_n_oe), 8'h00);
    for (k = 0; k < 9; k++) begin
      rate_pin_a <= 2'(pa[k]);
      rate_pin_b <= 2'(pb[k]);
      wt(10);
      chk("baud factor", 8'(baud), 8'(fac[k]));
    end
    rate_pin_a <= 2'h0;
    rate_pin_b <= 2'h0;
    link_established <= 1'h1;
    wt(10);
    chk("link status", 8'({link_n_oe, far_drive_en}), 8'h03);
    data_bus_idle <= 1'h0;
    far_int_n <= 1'h0;
    wt(1100);
    chk("mirrored interrupt", 8'(int_n_oe), 8'h00);
    data_bus_idle <= 1'h1;
    wt(1100);
    chk("mirrored interrupt", 8'(int_n_oe), 8'h01);
    far_int_n <= 1'h1;
    wt(1100);
    chk("mirrored interrupt", 8'(int_n_oe), 8'h00);
    far_rate_index <= 4'h7;
    wt(10);
    chk("link status", 8'(link_n_oe), 8'h00);
    far_select_n <= 3'h6;
    for (k = 0; k < 60 && far_bus_reset !== 1'h1; k++) wt(1);
    chk("stuck bus reset", 8'(far_bus_reset), 8'h01);
    far_select_n <= 3'h7;
    rd(sce_pkg::A_FAULT, 8'h0D);
    chk("far reset", 8'({far_reset_req, far_drive_en}), 8'h02);
    far_rate_index <= 4'h8;
    wt(10);
    chk("far reset", 8'({far_reset_req, far_drive_en}), 8'h01);
    enable_pin <= 1'h0;
    wt(40);
    chk("far reset", 8'(far_reset_req), 8'h00);
    wt(30);
    chk("far reset", 8'({far_reset_req, far_drive_en, low_power}), 8'h05);
    chk("word length", 8'(word_len), 8'h08);
    chk("mode config", 8'(mode_cfg), 8'h00);
    complete_run();
  end
endmodule
